// file: logic/pmr_pkg.sv
// Constants and types of the power-mode and reset sequencer
package pmr_pkg;
   localparam int          CLKS_PER_MCYCLE   = 4;
   localparam logic [1:0]  SAMPLE_PHASE      = 2'h3;
   localparam int          RST_HOLD_MCYCLES  = 2;
   localparam logic [11:0] RST_HOLD_CYCLES   =
      12'(RST_HOLD_MCYCLES * CLKS_PER_MCYCLE);
   localparam logic [11:0] POR_DELAY_CYCLES  = 12'h400;
   localparam logic [9:0]  WDT_RESET_DELAY   = 10'h200;
   localparam logic [7:0]  ADDR_POWER_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_WDOG_CTRL    = 8'h01;
   localparam int          POWER_CONTROL_REG_IDLE_BIT     = 0;
   localparam int          POWER_CONTROL_REG_PDOWN_BIT    = 1;
   localparam int          WDC_RESTART_BIT   = 0;
   localparam int          WDC_RST_EN_BIT    = 1;
   localparam int          WDC_WDT_FLAG_BIT  = 2;
   localparam int          WDC_INT_FLAG_BIT  = 3;
   localparam int          WDC_POR_FLAG_BIT  = 6;
   localparam logic [7:0]  RESET_PC          = 8'h00;

   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_IDLE  = 5'h02,
      ST_PDOWN = 5'h04,
      ST_WAKE  = 5'h08,
      ST_RESET = 5'h10
   } pmr_state_t;
endpackage

// file: logic/pmr_power_mode_reset_control.sv
// Power-mode and reset sequencer with register port
`timescale 1ns/100ps
module pmr_power_mode_reset_control
   import pmr_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       power_fail_in,
   input  wire logic       ext_reset_pin_in,
   input  wire logic [1:0] ext_int_n_in,
   input  wire logic [1:0] int_level_mode_in,
   input  wire logic [1:0] ext_int_enable_in,
   input  wire logic       global_interrupt_enable_in,
   input  wire logic       int_pending_in,
   input  wire logic       wdt_int_enable_in,
   input  wire logic       wdt_timeout_in,
   input  wire logic       instr_done_in,
   input  wire logic       cpu_ale_in,
   input  wire logic       cpu_program_store_strobe_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic [7:0]      reg_rdata_out,
   output logic            cpu_clk_en_out,
   output logic            periph_clk_en_out,
   output logic            osc_run_out,
   output logic            cpu_reset_out,
   output logic            addr_latch_strobe_out,
   output logic            program_store_strobe_out,
   output logic            port_hold_out,
   output logic            port_from_reg_out,
   output logic            wdt_restart_out,
   output logic            ext_reset_seen_out
);
   pmr_state_t  state_reg;
   pmr_state_t  state_next;
   logic [1:0]  phase_reg;
   logic        hi_seen_reg;
   logic [11:0] stretch_reg;
   logic [11:0] stretch_next;
   logic [9:0]  wdt_cnt_reg;
   logic        wdt_armed_reg;
   logic        idle_bit_reg;
   logic        pdown_bit_reg;
   logic        por_flag_reg;
   logic        wdt_flag_reg;
   logic        wdt_int_flag_reg;
   logic        wdt_rst_en_reg;
   logic        ext_detect;
   logic        wdt_fire;
   logic        rst_event;
   logic        level_wake;
   logic        idle_wake;
   logic        wr_power_control_reg;
   logic        wr_wdc;
   logic        clocks_on;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   assign wr_power_control_reg   = reg_wr_in && (reg_addr_in == ADDR_POWER_CTRL);
   assign wr_wdc    = reg_wr_in && (reg_addr_in == ADDR_WDOG_CTRL);
   assign clocks_on = (state_reg != ST_PDOWN);

   assign ext_detect = clocks_on && (phase_reg == SAMPLE_PHASE)
                       && ext_reset_pin_in && hi_seen_reg;
   assign wdt_fire   = clocks_on && wdt_armed_reg && wdt_rst_en_reg
                       && (wdt_cnt_reg == WDT_RESET_DELAY - 10'h001);
   assign rst_event  = power_fail_in || ext_detect || wdt_fire;
   assign level_wake = global_interrupt_enable_in && |(int_level_mode_in
                       & ext_int_enable_in & ~ext_int_n_in);
   assign idle_wake  = int_pending_in
                       || (wdt_int_flag_reg && wdt_int_enable_in);

   // Machine-cycle phase; frozen when the oscillator stops
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase_reg <= 2'h0;
      end else if (clocks_on) begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   // sample pin once per machine cycle
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hi_seen_reg <= 1'b0;
      end else if (clocks_on && phase_reg == SAMPLE_PHASE) begin
         hi_seen_reg <= ext_reset_pin_in;
      end
   end

   always_comb begin
      state_next   = state_reg;
      stretch_next = stretch_reg;
      if (power_fail_in) begin
         state_next   = ST_RESET;
         stretch_next = POR_DELAY_CYCLES - 12'h001;
      end else if (ext_detect || wdt_fire) begin
         state_next   = ST_RESET;
         stretch_next = RST_HOLD_CYCLES - 12'h001;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (instr_done_in && idle_bit_reg) begin
                  state_next = ST_IDLE;
               end else if (instr_done_in && pdown_bit_reg) begin
                  state_next = ST_PDOWN;
               end
            end
            ST_IDLE: begin
               if (idle_wake) begin
                  state_next = ST_RUN;
               end
            end
            ST_PDOWN: begin
               if (ext_reset_pin_in) begin
                  state_next = ST_WAKE;
               end else if (level_wake) begin
                  state_next = ST_RUN;
               end
            end
            ST_WAKE: begin
               // pin must stay high to be taken
               if (!ext_reset_pin_in && phase_reg == SAMPLE_PHASE) begin
                  state_next = ST_PDOWN;
               end
            end
            ST_RESET: begin
               // held while pin high, then stretch
               if (ext_reset_pin_in) begin
                  stretch_next = RST_HOLD_CYCLES - 12'h001;
               end else if (stretch_reg == 12'h000) begin
                  state_next = ST_RUN;
               end else begin
                  stretch_next = stretch_reg - 12'h001;
               end
            end
            default: begin
               state_next   = ST_RESET;
               stretch_next = RST_HOLD_CYCLES - 12'h001;
            end
         endcase
      end
   end

   // Power-on starts in the reset state with the full delay
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg   <= ST_RESET;
         stretch_reg <= POR_DELAY_CYCLES;
      end else begin
         state_reg   <= state_next;
         stretch_reg <= stretch_next;
      end
   end

   // Outputs follow the next state so they match state_reg
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cpu_clk_en_out           <= 1'b1;
         periph_clk_en_out        <= 1'b1;
         osc_run_out              <= 1'b1;
         cpu_reset_out            <= 1'b1;
         addr_latch_strobe_out    <= 1'b1;
         program_store_strobe_out <= 1'b1;
         port_hold_out            <= 1'b0;
         port_from_reg_out        <= 1'b0;
      end else begin
         // CPU clock off in idle and wake wait
         cpu_clk_en_out    <= (state_next == ST_RUN)
                              || (state_next == ST_RESET);
         periph_clk_en_out <= (state_next != ST_PDOWN);
         osc_run_out       <= (state_next != ST_PDOWN);
         // reset taken before any CPU clock edge
         cpu_reset_out     <= (state_next == ST_RESET);
         // strobes high and ports held in idle
         case (state_next)
            ST_IDLE: begin
               addr_latch_strobe_out    <= 1'b1;
               program_store_strobe_out <= 1'b1;
            end
            ST_PDOWN, ST_WAKE: begin
               addr_latch_strobe_out    <= 1'b0;
               program_store_strobe_out <= 1'b0;
            end
            default: begin
               addr_latch_strobe_out    <= cpu_ale_in;
               program_store_strobe_out <= cpu_program_store_strobe_in;
            end
         endcase
         port_hold_out     <= (state_next == ST_IDLE);
         port_from_reg_out <= (state_next == ST_PDOWN)
                              || (state_next == ST_WAKE);
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wdt_armed_reg <= 1'b0;
         wdt_cnt_reg   <= 10'h000;
      end else if (rst_event || !wdt_rst_en_reg
                   || (wr_wdc && reg_wdata_in[WDC_RESTART_BIT])) begin
         wdt_armed_reg <= 1'b0;
         wdt_cnt_reg   <= 10'h000;
      end else if (clocks_on && wdt_timeout_in) begin
         wdt_armed_reg <= 1'b1;
         wdt_cnt_reg   <= 10'h000;
      end else if (clocks_on && wdt_armed_reg) begin
         wdt_cnt_reg   <= wdt_cnt_reg + 10'h001;
      end
   end

   // Restart pulse to the watchdog; the restart bit self-clears
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wdt_restart_out    <= 1'b0;
         ext_reset_seen_out <= 1'b0;
      end else begin
         wdt_restart_out    <= wr_wdc && reg_wdata_in[WDC_RESTART_BIT];
         ext_reset_seen_out <= ext_detect;
      end
   end

   // Mode bits; hardware clears win over a software write
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         idle_bit_reg  <= 1'b0;
         pdown_bit_reg <= 1'b0;
      end else if (rst_event) begin
         // every reset clears both mode bits
         // control state back to reset values
         idle_bit_reg  <= 1'b0;
         pdown_bit_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && idle_wake) begin
         idle_bit_reg  <= 1'b0;
      end else if (state_reg == ST_PDOWN
                   && (ext_reset_pin_in || level_wake)) begin
         pdown_bit_reg <= 1'b0;
      end else if (wr_power_control_reg) begin
         idle_bit_reg  <= reg_wdata_in[POWER_CONTROL_REG_IDLE_BIT];
         pdown_bit_reg <= reg_wdata_in[POWER_CONTROL_REG_PDOWN_BIT];
      end
   end

   // Source flags; a hardware set wins over a software clear
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         por_flag_reg     <= 1'b1;
         wdt_flag_reg     <= 1'b0;
         wdt_rst_en_reg   <= 1'b0;
         wdt_int_flag_reg <= 1'b0;
      end else if (power_fail_in) begin
         por_flag_reg     <= 1'b1;
         wdt_flag_reg     <= 1'b0;
         wdt_rst_en_reg   <= 1'b0;
         wdt_int_flag_reg <= 1'b0;
      end else begin
         if (wr_wdc) begin
            por_flag_reg <= reg_wdata_in[WDC_POR_FLAG_BIT];
         end
         if (wdt_fire) begin
            wdt_flag_reg <= 1'b1;
         end else if (wr_wdc) begin
            wdt_flag_reg <= reg_wdata_in[WDC_WDT_FLAG_BIT];
         end
         if (wr_wdc && !rst_event) begin
            wdt_rst_en_reg <= reg_wdata_in[WDC_RST_EN_BIT];
         end
         // timeout raises the watchdog interrupt flag
         if (clocks_on && wdt_timeout_in) begin
            wdt_int_flag_reg <= 1'b1;
         end else if (rst_event) begin
            wdt_int_flag_reg <= 1'b0;
         end else if (wr_wdc) begin
            wdt_int_flag_reg <= reg_wdata_in[WDC_INT_FLAG_BIT];
         end
      end
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in && reg_addr_in == ADDR_POWER_CTRL) begin
         reg_rdata_out <= {6'h00, pdown_bit_reg, idle_bit_reg};
      end else if (reg_rd_in && reg_addr_in == ADDR_WDOG_CTRL) begin
         reg_rdata_out <= {1'b0, por_flag_reg, 2'h0, wdt_int_flag_reg,
                           wdt_flag_reg, wdt_rst_en_reg, 1'b0};
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   sequence s_two_highs;
      (clocks_on && phase_reg == SAMPLE_PHASE && ext_reset_pin_in) ##4
      (phase_reg == SAMPLE_PHASE && ext_reset_pin_in);
   endsequence
   sequence s_pin_released;
      state_reg == ST_RESET && !ext_reset_pin_in && !rst_event
      && stretch_reg == RST_HOLD_CYCLES - 12'h001;
   endsequence

   chk_idle_entry: assert property (
      state_reg == ST_RUN && instr_done_in && idle_bit_reg && !rst_event
      |=> state_reg == ST_IDLE)
      else $error("idle not entered after instruction");
   chk_idle_clocks: assert property (
      state_reg == ST_IDLE |-> !cpu_clk_en_out && periph_clk_en_out)
      else $error("wrong clock gating in idle");
   chk_idle_pins: assert property (
      state_reg == ST_IDLE |-> addr_latch_strobe_out
      && program_store_strobe_out && port_hold_out)
      else $error("idle pin state wrong");
   chk_idle_wakeup: assert property (
      state_reg == ST_IDLE && idle_wake && !rst_event
      |=> state_reg == ST_RUN && !idle_bit_reg)
      else $error("interrupt did not end idle");
   chk_wdt_reset: assert property (
      wdt_fire && !power_fail_in |=> cpu_reset_out && wdt_flag_reg
      ##1 cpu_reset_out [*7])
      else $error("watchdog reset not held two cycles");
   chk_pdown_pins: assert property (
      state_reg == ST_PDOWN |-> !addr_latch_strobe_out
      && !program_store_strobe_out && !osc_run_out && port_from_reg_out)
      else $error("power-down pin state wrong");
   chk_pdown_wdt: assert property (
      state_reg == ST_PDOWN && $past(state_reg) == ST_PDOWN
      |-> $stable(wdt_cnt_reg) && !wdt_fire)
      else $error("watchdog moved in power-down");
   chk_pdown_pin_wake: assert property (
      state_reg == ST_PDOWN && ext_reset_pin_in && !power_fail_in
      |=> state_reg == ST_WAKE && osc_run_out && !pdown_bit_reg)
      else $error("reset pin did not restart clock");
   chk_level_wake: assert property (
      state_reg == ST_PDOWN && level_wake && !ext_reset_pin_in
      && !power_fail_in |=> state_reg == ST_RUN && !pdown_bit_reg)
      else $error("level interrupt did not wake");
   chk_ext_detect: assert property (
      s_two_highs ##0 (clocks_on && !power_fail_in && !wdt_fire)
      |=> state_reg == ST_RESET)
      else $error("two high samples missed");
   chk_rst_stretch: assert property (
      s_pin_released ##1 (!ext_reset_pin_in && !rst_event) [*7]
      |=> state_reg == ST_RUN && !cpu_reset_out)
      else $error("reset stretch length wrong");
   chk_ext_no_flag: assert property (
      ext_detect && !wdt_fire && !power_fail_in && !wr_wdc
      |=> $stable(por_flag_reg) && $stable(wdt_flag_reg))
      else $error("external reset changed a flag");
   chk_por_flag: assert property (
      power_fail_in |=> por_flag_reg && !wdt_flag_reg && cpu_reset_out)
      else $error("power failure recovery wrong");
endmodule // pmr_power_mode_reset_control

// file: testbench/pmr_ext_source.sv
// Model of the external reset source and interrupt pins
`timescale 1ns/100ps
module pmr_ext_source (
   input  wire logic  ref_clk_in,
   output logic       ext_reset_pin_out,
   output logic [1:0] ext_int_n_out
);
   initial begin
      ext_reset_pin_out = 1'b0;
      ext_int_n_out     = 2'h3;
   end

   // pin held n clocks
   // Held for fewer than eight only when a scenario asks for a short pulse
   task automatic hold_reset(input int n);
      @(posedge ref_clk_in);
      ext_reset_pin_out <= 1'b1;
      repeat (n) @(posedge ref_clk_in);
      ext_reset_pin_out <= 1'b0;
   endtask

   task automatic drive_int(input int i, input logic low);
      @(posedge ref_clk_in);
      ext_int_n_out[i] <= ~low;
   endtask
endmodule // pmr_ext_source

// file: testbench/pmr_power_mode_reset_control_tb_top.sv
// Self-checking bench of the power-mode and reset sequencer
`timescale 1ns/100ps
module pmr_power_mode_reset_control_tb_top;
   import pmr_pkg::*;
   logic       clk, rst_n, pfail, int_pend, wdt_ie, wdt_to, done;
   logic       ale, program_store_strobe, wr, rd, gie, pin, cpu_clk, per_clk, osc;
   logic       cpu_rst, ale_o, program_store_strobe_o, hold, from_reg, restart, seen;
   logic [1:0] lvl, ien, int_n;
   logic [7:0] addr, wdata, rdata, rv;
   int         error_cnt, compares, n, seen_cnt, rs_cnt;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   pmr_ext_source src (.ref_clk_in(clk), .ext_reset_pin_out(pin),
      .ext_int_n_out(int_n));

   pmr_power_mode_reset_control dut (.ref_clk_in(clk), .reset_n_in(rst_n),
      .power_fail_in(pfail), .ext_reset_pin_in(pin), .ext_int_n_in(int_n),
      .int_level_mode_in(lvl), .ext_int_enable_in(ien),
      .global_interrupt_enable_in(gie), .int_pending_in(int_pend),
      .wdt_int_enable_in(wdt_ie), .wdt_timeout_in(wdt_to),
      .instr_done_in(done), .cpu_ale_in(ale), .cpu_program_store_strobe_in(program_store_strobe),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .cpu_clk_en_out(cpu_clk),
      .periph_clk_en_out(per_clk), .osc_run_out(osc),
      .cpu_reset_out(cpu_rst), .addr_latch_strobe_out(ale_o),
      .program_store_strobe_out(program_store_strobe_o), .port_hold_out(hold),
      .port_from_reg_out(from_reg), .wdt_restart_out(restart),
      .ext_reset_seen_out(seen));

   // One-cycle pulses are counted as they go by
   always @(posedge clk) begin
      if (seen === 1'b1) seen_cnt++;
      if (restart === 1'b1) rs_cnt++;
   end

   task automatic chk1(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
      chk8(nm, e, rv);
   endtask

   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: done <= 1'b1;
         1: int_pend <= 1'b1;
         default: wdt_to <= 1'b1;
      endcase
      @(posedge clk);
      done <= 1'b0;
      int_pend <= 1'b0;
      wdt_to <= 1'b0;
      #1;
   endtask

   // Bounded wait; n keeps counting from wherever the caller left it
   task automatic wait_rst(input logic l, input int max);
      while (cpu_rst !== l && n < max) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   task automatic t_por();
      n = 0;
      wait_rst(1'b0, 1100);
      chk1("por_release", 1'b0, cpu_rst);
      rd_chk("watchdog_control_reg_por", ADDR_WDOG_CTRL, 8'h40);
      reg_wr(8'h07, 8'hFF);
      rd_chk("unmapped", 8'h07, 8'h00);
      rd_chk("power_control_reg_init", ADDR_POWER_CTRL, 8'h00);
      reg_wr(ADDR_WDOG_CTRL, 8'h00);
      rd_chk("watchdog_control_reg_clr", ADDR_WDOG_CTRL, 8'h00);
   endtask

   task automatic t_idle();
      @(posedge clk);
      ale <= 1'b0;
      program_store_strobe <= 1'b0;
      reg_wr(ADDR_POWER_CTRL, 8'h01);
      pulse(0);
      chk1("cpu_clk", 1'b0, cpu_clk);
      chk1("periph_clk", 1'b1, per_clk);
      chk1("ale", 1'b1, ale_o);
      chk1("program_store_strobe", 1'b1, program_store_strobe_o);
      chk1("port_hold", 1'b1, hold);
      pulse(1);
      chk1("cpu_clk", 1'b1, cpu_clk);
      chk1("ale_run", 1'b0, ale_o);
      chk1("program_store_strobe_run", 1'b0, program_store_strobe_o);
      rd_chk("power_control_reg", ADDR_POWER_CTRL, 8'h00);
   endtask

   task automatic t_pdown();
      @(posedge clk);
      ale <= 1'b1;
      program_store_strobe <= 1'b1;
      lvl <= 2'h2;
      ien <= 2'h2;
      gie <= 1'b1;
      reg_wr(ADDR_WDOG_CTRL, 8'h02);
      reg_wr(ADDR_POWER_CTRL, 8'h02);
      pulse(0);
      chk1("osc", 1'b0, osc);
      chk1("periph_clk", 1'b0, per_clk);
      chk1("ale", 1'b0, ale_o);
      chk1("program_store_strobe", 1'b0, program_store_strobe_o);
      chk1("port_from_reg", 1'b1, from_reg);
      pulse(2);
      repeat (600) @(posedge clk);
      #1 chk1("cpu_reset", 1'b0, cpu_rst);
      src.drive_int(1, 1'b1);
      n = 0;
      while (cpu_clk !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk1("level_wake", 1'b1, cpu_clk);
      src.drive_int(1, 1'b0);
      rd_chk("power_control_reg", ADDR_POWER_CTRL, 8'h00);
   endtask

   task automatic t_ext_pd();
      seen_cnt = 0;
      reg_wr(ADDR_POWER_CTRL, 8'h02);
      pulse(0);
      src.hold_reset(12);
      #1 chk1("cpu_reset", 1'b1, cpu_rst);
      chk1("osc", 1'b1, osc);
      n = 0;
      wait_rst(1'b0, 20);
      chk1("reset_tail", 1'b1, n >= 1 && n <= 10);
      chk1("seen", 1'b1, seen_cnt > 0);
      rd_chk("power_control_reg", ADDR_POWER_CTRL, 8'h00);
      rd_chk("watchdog_control_reg", ADDR_WDOG_CTRL, 8'h02);
   endtask

   task automatic t_short();
      seen_cnt = 0;
      src.hold_reset(3);
      repeat (20) @(posedge clk);
      #1 chk1("cpu_reset", 1'b0, cpu_rst);
      chk1("seen", 1'b1, seen_cnt == 0);
   endtask

   task automatic t_idle_rst();
      reg_wr(ADDR_POWER_CTRL, 8'h01);
      pulse(0);
      src.hold_reset(12);
      #1 chk1("cpu_reset", 1'b1, cpu_rst);
      chk1("cpu_clk", 1'b1, cpu_clk);
      n = 0;
      wait_rst(1'b0, 20);
      rd_chk("power_control_reg", ADDR_POWER_CTRL, 8'h00);
   endtask

   task automatic t_wdog();
      @(posedge clk);
      wdt_ie <= 1'b1;
      reg_wr(ADDR_POWER_CTRL, 8'h01);
      pulse(0);
      pulse(2);
      @(posedge clk);
      #1 chk1("wdt_wake", 1'b1, cpu_clk);
      n = 1;
      wait_rst(1'b1, 600);
      chk1("wdt_delay", 1'b1, n == 512);
      n = 0;
      wait_rst(1'b0, 30);
      chk1("wdt_hold", 1'b1, n == 8);
      rd_chk("watchdog_control_reg", ADDR_WDOG_CTRL, 8'h06);
      rs_cnt = 0;
      pulse(2);
      repeat (100) @(posedge clk);
      reg_wr(ADDR_WDOG_CTRL, 8'h07);
      repeat (600) @(posedge clk);
      #1 chk1("restarted", 1'b0, cpu_rst);
      chk1("restart_pulse", 1'b1, rs_cnt == 1);
   endtask

   task automatic t_pfail();
      @(posedge clk);
      pfail <= 1'b1;
      repeat (3) @(posedge clk);
      pfail <= 1'b0;
      #1 chk1("cpu_reset", 1'b1, cpu_rst);
      n = 0;
      wait_rst(1'b0, 1100);
      chk1("pf_release", 1'b0, cpu_rst);
      rd_chk("watchdog_control_reg", ADDR_WDOG_CTRL, 8'h40);
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Tests need about 4000 cycles; six times that cuts a hang
   initial begin
      #240000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      {rst_n, pfail, int_pend, wdt_ie, wdt_to, done} = 6'h00;
      {ale, program_store_strobe, wr, rd, gie} = 5'h00;
      {lvl, ien, addr, wdata} = 20'h00000;
      {error_cnt, compares, seen_cnt, rs_cnt} = {4{32'h0}};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_por();
      t_idle();
      t_pdown();
      t_ext_pd();
      t_short();
      t_idle_rst();
      t_wdog();
      t_pfail();
      give_verdict();
   end
endmodule // pmr_power_mode_reset_control_tb_top
